// ---- verilog/pmic_pins_pkg.sv ----
/*
  constants for the power-manager control pin logic: register map, field
  positions, rail numbering, wake states and timing counts.
  assumes a 10 MHz clock and a 32-bit apb register bus.
*/
package pmic_pins_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] VSEL_OFFSET   = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] CLEAR_OFFSET  = 8'h0c;

  // rails and dacs
  localparam int RAIL_COUNT = 7;
  localparam int DAC_COUNT  = 4;
  localparam int LINEAR_C   = 5;
  localparam int LINEAR_D   = 6;

  // control register fields
  localparam int CTRL_SW_ONLY_BIT  = 8;
  localparam int CTRL_LIN_D_OFF_BIT = 9;
  localparam int CTRL_SLEW_MASK_BIT = 10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_077f;
  localparam logic [3:0]  VSEL_RESET = 4'h0;

  // interrupt cause bits
  localparam int CAUSE_COUNT     = 6;
  localparam int CAUSE_PG_FAULT  = 0;
  localparam int CAUSE_UV_WARN   = 1;
  localparam int CAUSE_OT_WARN   = 2;
  localparam int CAUSE_UV_FAULT  = 3;
  localparam int CAUSE_OT_FAULT  = 4;
  localparam int CAUSE_HARD_RST  = 5;

  // status register fields
  localparam int STATUS_PRESS_BIT = 8;
  localparam int STATUS_WAKE_BIT  = 9;
  localparam int STATUS_OK_BIT    = 10;
  localparam int STATUS_STATE_LSB = 12;

  // wake sequencer states
  typedef enum logic [2:0] {
    st_off   = 3'b000,
    st_wait  = 3'b001,
    st_on    = 3'b010,
    st_blank = 3'b011,
    st_hard  = 3'b100
  } wake_state_type;

  // timing
  localparam int CLK_KHZ            = 10000;
  localparam int CLK_MHZ            = 10;
  localparam int ENABLE_DELAY_US    = 200;
  localparam int DEBOUNCE_MS        = 50;
  localparam int WAKE_PRESS_MS      = 400;
  localparam int HARD_PRESS_MS      = 5000;
  localparam int ACK_TIMEOUT_MS     = 5000;
  localparam int HARD_HOLD_MS       = 1000;
  localparam int WAKE_OFF_MS        = 1000;
  localparam int ENABLE_DELAY_CYCLES = ENABLE_DELAY_US * CLK_MHZ;
  localparam int DEBOUNCE_CYCLES     = DEBOUNCE_MS * CLK_KHZ;
  localparam int WAKE_PRESS_CYCLES   = WAKE_PRESS_MS * CLK_KHZ;
  localparam int HARD_PRESS_CYCLES   = HARD_PRESS_MS * CLK_KHZ;
  localparam int ACK_TIMEOUT_CYCLES  = ACK_TIMEOUT_MS * CLK_KHZ;
  localparam int HARD_HOLD_CYCLES    = HARD_HOLD_MS * CLK_KHZ;
  localparam int WAKE_OFF_CYCLES     = WAKE_OFF_MS * CLK_KHZ;

endpackage

// ---- verilog/delay_filter.sv ----
/*
  level delay filter: the output takes the input's level once the input has
  differed from it for DELAY consecutive clocks.
  assumes the input is synchronous to clk.
*/
`timescale 1ns/1ps
module delay_filter #(
  parameter int unsigned DELAY = 1
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // level in and out
  input  wire logic in_level,
  output logic      out_level
);

  logic [31:0] count;
  logic [31:0] next_count;
  logic        next_out;

  always_comb begin
    next_count = 32'h0000_0000;
    next_out   = out_level;
    if (in_level != out_level) begin
      if (count == 32'(DELAY - 1)) begin
        next_out = in_level;
      end else begin
        next_count = count + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count     <= 32'h0000_0000;
      out_level <= 1'b0;
    end else begin
      count     <= next_count;
      out_level <= next_out;
    end
  end

endmodule

// ---- verilog/pmic_control_pin_logic.sv ----
/*
  control and status pin logic of a multi-rail power manager: pushbutton,
  wake handshake, reset and interrupt pins, rail enables, standby dac select,
  power-good and an apb register file.
  assumes all pin inputs synchronous to clk; open-drain pins are driven low
  outside while their _oe output is high.
*/
// Overview of operation
// - reset pin pulled low while always-on rail is low or hard reset runs
// - rail enable pins are active high; low disables the rail
// - shared pin enables linear c and d; software may still switch d off
// - interrupt pin pulled low on power-good, undervoltage or overtemperature
// - interrupt released only by a write to the clear command register
// - power ack high activates wake; power ack low shuts wake down
// - pushbutton low means pressed, high means released
// - button status follows the pushbutton after a 50 ms debounce
// - wake releases high on button activation or power ack
// - with standby low each dac target comes from the select register bits
// - with standby high every dac uses its second target voltage
// - power-good low when any enabled rail is bad, or slewing unless masked
// - power-good low when every rail is disabled
// - control and select registers return to reset values while the serial supply is below 1 V; latched causes are kept
// - button held 400 ms releases wake high
// - button held 5 s: rails off, wake low, reset low 1 s, inputs ignored
// - internal rail enable follows its pin after 200 us
// - a rail re-enables only after its output discharged below 300 mV
`timescale 1ns/1ps
module pmic_control_pin_logic #(
  parameter int unsigned DEBOUNCE_CYCLES    = pmic_pins_pkg::DEBOUNCE_CYCLES,
  parameter int unsigned WAKE_PRESS_CYCLES  = pmic_pins_pkg::WAKE_PRESS_CYCLES,
  parameter int unsigned HARD_PRESS_CYCLES  = pmic_pins_pkg::HARD_PRESS_CYCLES,
  parameter int unsigned ACK_TIMEOUT_CYCLES = pmic_pins_pkg::ACK_TIMEOUT_CYCLES,
  parameter int unsigned HARD_HOLD_CYCLES   = pmic_pins_pkg::HARD_HOLD_CYCLES,
  parameter int unsigned WAKE_OFF_CYCLES    = pmic_pins_pkg::WAKE_OFF_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // pushbutton and host handshake
  input  wire logic        press_n,
  input  wire logic        host_power_ack,
  output logic             button_status_oe,
  output logic             wake_oe,
  output logic             reset_out_n_oe,
  output logic             interrupt_n_oe,
  // rail enable pins
  input  wire logic        buck_a_enable,
  input  wire logic        buck_b_enable,
  input  wire logic        buck_c_enable,
  input  wire logic        buckboost_enable,
  input  wire logic        linear_b_enable,
  input  wire logic        linear_cd_enable,
  // analog monitors
  input  wire logic        always_on_linear_ok,
  input  wire logic        serial_logic_supply_ok,
  input  wire logic [6:0]  rail_good,
  input  wire logic [6:0]  rail_discharged,
  input  wire logic        dac_slewing,
  input  wire logic        undervolt_warn,
  input  wire logic        overtemp_warn,
  input  wire logic        undervolt_fault,
  input  wire logic        overtemp_fault,
  // rail and dac control
  input  wire logic        standby_select,
  output logic [6:0]       rail_enable,
  output logic [3:0]       second_target_voltage,
  output logic             rails_ok_out_oe
);

  pmic_pins_pkg::wake_state_type state;
  pmic_pins_pkg::wake_state_type next_state;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic [31:0] hold;
  logic [31:0] next_hold;
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [3:0]  voltage_control_cmd;
  logic [3:0]  next_vsel;
  logic [5:0]  cause;
  logic [5:0]  next_cause;
  logic [31:0] next_prdata;
  logic [6:0]  next_rail_enable;
  logic [6:0]  rail_request;
  logic [6:0]  rail_follow;
  logic [3:0]  next_second;
  logic        next_wake_oe;
  logic        next_reset_oe;
  logic        next_irq_oe;
  logic        next_ok_oe;
  logic        next_status_oe;
  logic        pressed;
  logic        press_filtered;
  logic        inhibit;
  logic        wake_press;
  logic        hard_press;
  logic        wr_access;
  logic        rd_setup;
  logic        mapped;
  logic        clear_write;
  logic [5:0]  events;

  assign inhibit = (state == pmic_pins_pkg::st_hard);
  // low level is a press, ignored while inhibited
  assign pressed = !press_n && !inhibit;
  assign wake_press = (hold == 32'(WAKE_PRESS_CYCLES));
  assign hard_press = (hold == 32'(HARD_PRESS_CYCLES));

  // apb decode
  assign mapped = (paddr == pmic_pins_pkg::CTRL_OFFSET) || (paddr == pmic_pins_pkg::VSEL_OFFSET)
               || (paddr == pmic_pins_pkg::STATUS_OFFSET) || (paddr == pmic_pins_pkg::CLEAR_OFFSET);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_access = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign clear_write = wr_access && (paddr == pmic_pins_pkg::CLEAR_OFFSET);

  // rail requests: pins or software-only enables
  always_comb begin
    rail_request = {linear_cd_enable, linear_cd_enable, linear_b_enable,
                    buckboost_enable, buck_c_enable, buck_b_enable, buck_a_enable};
    if (ctrl[pmic_pins_pkg::CTRL_SW_ONLY_BIT]) begin
      rail_request = ctrl[6:0];
    end
    if (ctrl[pmic_pins_pkg::CTRL_LIN_D_OFF_BIT]) begin
      rail_request[pmic_pins_pkg::LINEAR_D] = 1'b0;
    end
    if (inhibit) begin
      rail_request = 7'h00;
    end
  end

  // per-rail enable delay
  genvar r;
  generate
    for (r = 0; r < pmic_pins_pkg::RAIL_COUNT; r++) begin : g_rail
      delay_filter #(
        .DELAY (pmic_pins_pkg::ENABLE_DELAY_CYCLES)
      ) u_rail_delay (
        .clk       (clk),
        .resetn    (resetn),
        .in_level  (rail_request[r]),
        .out_level (rail_follow[r])
      );
    end
  endgenerate

  // button debounce
  delay_filter #(
    .DELAY (DEBOUNCE_CYCLES)
  ) u_debounce (
    .clk       (clk),
    .resetn    (resetn),
    .in_level  (pressed),
    .out_level (press_filtered)
  );

  // wake sequencer and button hold counter
  always_comb begin
    next_state = state;
    next_timer = timer + 32'h0000_0001;
    next_hold = (pressed && !hard_press) ? hold + 32'h0000_0001 : (pressed ? hold : 32'h0);
    if (hard_press) begin
      next_state = pmic_pins_pkg::st_hard;
      next_timer = 32'h0;
    end else begin
      case (state)
        pmic_pins_pkg::st_off: begin
          if (host_power_ack) begin
            next_state = pmic_pins_pkg::st_on;
            next_timer = 32'h0;
          end else if (wake_press) begin
            next_state = pmic_pins_pkg::st_wait;
            next_timer = 32'h0;
          end
        end
        pmic_pins_pkg::st_wait: begin
          if (host_power_ack) begin
            next_state = pmic_pins_pkg::st_on;
          end else if (timer == 32'(ACK_TIMEOUT_CYCLES - 1)) begin
            next_state = pmic_pins_pkg::st_blank;
            next_timer = 32'h0;
          end
        end
        pmic_pins_pkg::st_on: begin
          if (!host_power_ack) begin
            next_state = pmic_pins_pkg::st_blank;
            next_timer = 32'h0;
          end
        end
        pmic_pins_pkg::st_blank: begin
          if (timer == 32'(WAKE_OFF_CYCLES - 1)) begin
            next_state = pmic_pins_pkg::st_off;
          end
        end
        pmic_pins_pkg::st_hard: begin
          next_hold = 32'h0;
          if (timer == 32'(HARD_HOLD_CYCLES - 1)) begin
            next_state = pmic_pins_pkg::st_off;
          end
        end
        default: begin
          next_state = pmic_pins_pkg::st_off;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= pmic_pins_pkg::st_off;
      timer <= 32'h0;
      hold  <= 32'h0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      hold  <= next_hold;
    end
  end

  // registers and interrupt causes
  always_comb begin
    next_ctrl = ctrl;
    next_vsel = voltage_control_cmd;
    next_prdata = prdata;
    events = '0;
    events[pmic_pins_pkg::CAUSE_PG_FAULT] = |(rail_enable & ~rail_good);
    events[pmic_pins_pkg::CAUSE_UV_WARN]  = undervolt_warn;
    events[pmic_pins_pkg::CAUSE_OT_WARN]  = overtemp_warn;
    events[pmic_pins_pkg::CAUSE_UV_FAULT] = undervolt_fault;
    events[pmic_pins_pkg::CAUSE_OT_FAULT] = overtemp_fault;
    events[pmic_pins_pkg::CAUSE_HARD_RST] = hard_press;
    // set wins over clear
    next_cause = (clear_write ? 6'h00 : cause) | events;
    if (wr_access && paddr == pmic_pins_pkg::CTRL_OFFSET) begin
      next_ctrl = pwdata & pmic_pins_pkg::CTRL_MASK;
    end
    if (wr_access && paddr == pmic_pins_pkg::VSEL_OFFSET) begin
      next_vsel = pwdata[3:0];
    end
    if (rd_setup) begin
      case (paddr)
        pmic_pins_pkg::CTRL_OFFSET:   next_prdata = ctrl;
        pmic_pins_pkg::VSEL_OFFSET:   next_prdata = {28'h0, voltage_control_cmd};
        pmic_pins_pkg::STATUS_OFFSET: begin
          next_prdata = {26'h0, cause};
          next_prdata[pmic_pins_pkg::STATUS_PRESS_BIT] = press_filtered;
          next_prdata[pmic_pins_pkg::STATUS_WAKE_BIT] = !wake_oe;
          next_prdata[pmic_pins_pkg::STATUS_OK_BIT] = !rails_ok_out_oe;
          next_prdata[pmic_pins_pkg::STATUS_STATE_LSB +: 3] = state;
        end
        default: next_prdata = 32'h0;
      endcase
    end
    if (!serial_logic_supply_ok) begin
      next_ctrl = pmic_pins_pkg::CTRL_RESET;
      next_vsel = pmic_pins_pkg::VSEL_RESET;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= pmic_pins_pkg::CTRL_RESET;
      voltage_control_cmd <= pmic_pins_pkg::VSEL_RESET;
      cause <= 6'h00;
      prdata <= 32'h0;
    end else begin
      ctrl <= next_ctrl;
      voltage_control_cmd <= next_vsel;
      cause <= next_cause;
      prdata <= next_prdata;
    end
  end

  // pin outputs
  always_comb begin
    for (int i = 0; i < pmic_pins_pkg::RAIL_COUNT; i++) begin
      next_rail_enable[i] = rail_follow[i] && !inhibit
                         && (rail_enable[i] || rail_discharged[i]);
    end
    next_second = standby_select_vec(voltage_control_cmd);
    next_wake_oe = !(state == pmic_pins_pkg::st_wait || state == pmic_pins_pkg::st_on);
    next_reset_oe = !always_on_linear_ok || inhibit;
    next_irq_oe = |next_cause;
    next_status_oe = press_filtered;
    next_ok_oe = |(rail_enable & ~rail_good)
              || (dac_slewing && !ctrl[pmic_pins_pkg::CTRL_SLEW_MASK_BIT])
              || (rail_enable == 7'h00);
  end

  function automatic logic [3:0] standby_select_vec(input logic [3:0] sel);
    standby_select_vec = standby_select ? 4'hf : sel;
  endfunction

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rail_enable <= 7'h00;
      second_target_voltage <= 4'h0;
      wake_oe <= 1'b1;
      reset_out_n_oe <= 1'b1;
      interrupt_n_oe <= 1'b0;
      button_status_oe <= 1'b0;
      rails_ok_out_oe <= 1'b1;
    end else begin
      rail_enable <= next_rail_enable;
      second_target_voltage <= next_second;
      wake_oe <= next_wake_oe;
      reset_out_n_oe <= next_reset_oe;
      interrupt_n_oe <= next_irq_oe;
      button_status_oe <= next_status_oe;
      rails_ok_out_oe <= next_ok_oe;
    end
  end

  // checks
  sequence s_hard_entry;
    hard_press ##1 (state == pmic_pins_pkg::st_hard);
  endsequence

  property p_reset_low;
    @(posedge clk) disable iff (!resetn) !always_on_linear_ok |=> reset_out_n_oe;
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("reset pin not low");

  property p_lin_cd;
    @(posedge clk) disable iff (!resetn) !ctrl[8] && !inhibit |->
      rail_request[5] == linear_cd_enable && rail_request[6] == (linear_cd_enable && !ctrl[9]);
  endproperty
  a_lin_cd: assert property (p_lin_cd) else $error("shared enable wrong");

  property p_irq_set;
    @(posedge clk) disable iff (!resetn) overtemp_warn || undervolt_warn |=> interrupt_n_oe;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("interrupt not asserted");

  property p_irq_hold;
    @(posedge clk) disable iff (!resetn) interrupt_n_oe && !clear_write |=> interrupt_n_oe;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped");

  property p_ack_off;
    @(posedge clk) disable iff (!resetn)
      state == pmic_pins_pkg::st_on && !host_power_ack && !hard_press |=> ##1 wake_oe;
  endproperty
  a_ack_off: assert property (p_ack_off) else $error("wake not shut down");

  property p_standby;
    @(posedge clk) disable iff (!resetn) standby_select |=> second_target_voltage == 4'hf;
  endproperty
  a_standby: assert property (p_standby) else $error("standby select ignored");

  property p_vsel;
    @(posedge clk) disable iff (!resetn)
      !standby_select |=> second_target_voltage == $past(voltage_control_cmd);
  endproperty
  a_vsel: assert property (p_vsel) else $error("dac select wrong");

  property p_all_off;
    @(posedge clk) disable iff (!resetn) rail_enable == 7'h00 |=> rails_ok_out_oe;
  endproperty
  a_all_off: assert property (p_all_off) else $error("power good with rails off");

  property p_hard;
    @(posedge clk) disable iff (!resetn) s_hard_entry |=> reset_out_n_oe && wake_oe;
  endproperty
  a_hard: assert property (p_hard) else $error("hard reset not applied");

endmodule

// ---- verif/host_button_model.sv ----
/*
  host processor and pushbutton model: presses the button on command and
  answers a released wake line with the power-on acknowledge.
  assumes the bench commands it just after the rising clock edge.
*/
`timescale 1ns/1ps
module host_button_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // commands from the bench
  input  wire logic       press_req,
  input  wire logic       ack_enable,
  input  wire logic [7:0] ack_delay,
  // device pins
  input  wire logic       wake_oe,
  output logic            press_n,
  output logic            host_power_ack
);
  logic [7:0] count;

  // open button line floats high through its pull-up
  assign press_n = press_req ? 1'b0 : 1'b1;

  // acknowledge a released wake after the programmed delay
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= 8'h00;
      host_power_ack <= 1'b0;
    end else if (wake_oe || !ack_enable) begin
      count <= 8'h00;
      host_power_ack <= 1'b0;
    end else if (count >= ack_delay) begin
      host_power_ack <= 1'b1;
    end else begin
      count <= count + 8'h01;
    end
  end
endmodule

// ---- verif/pmic_control_pin_logic_bench.sv ----
/*
  self-checking bench for the control pin logic: apb master, expectation
  queue with a watching process, and the scenario list.
  assumes shortened timing parameters and the host model beside the dut.
*/
`timescale 1ns/1ps
module pmic_control_pin_logic_bench;
  typedef struct {
    string       name;
    int          sel;
    logic [31:0] exp;
  } note_type;

  localparam int unsigned DEB  = 20;
  localparam int unsigned WAKE = 40;
  localparam int unsigned HARD = 200;
  localparam int unsigned ACKT = 100;
  localparam int unsigned HOLD = 50;
  localparam int unsigned WOFF = 50;

  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, ack_delay;
  logic [31:0] pwdata, prdata, rd;
  logic        press_n, host_power_ack, press_req, ack_enable;
  logic        button_status_oe, wake_oe, reset_out_n_oe, interrupt_n_oe;
  logic [5:0]  pin_en;
  logic [3:0]  cond, second_target_voltage, v;
  logic        always_on_linear_ok, serial_logic_supply_ok, dac_slewing;
  logic        rails_ok_out_oe, standby_select;
  logic [6:0]  rail_good, rail_discharged, rail_enable;
  note_type    notes[$];
  note_type    cur;
  int          err_count, n_compared;
  event        result_ev;

  pmic_control_pin_logic #(.DEBOUNCE_CYCLES(DEB), .WAKE_PRESS_CYCLES(WAKE),
    .HARD_PRESS_CYCLES(HARD), .ACK_TIMEOUT_CYCLES(ACKT), .HARD_HOLD_CYCLES(HOLD),
    .WAKE_OFF_CYCLES(WOFF)) u_dut (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .press_n(press_n),
    .host_power_ack(host_power_ack), .button_status_oe(button_status_oe),
    .wake_oe(wake_oe), .reset_out_n_oe(reset_out_n_oe),
    .interrupt_n_oe(interrupt_n_oe), .buck_a_enable(pin_en[0]),
    .buck_b_enable(pin_en[1]), .buck_c_enable(pin_en[2]),
    .buckboost_enable(pin_en[3]), .linear_b_enable(pin_en[4]),
    .linear_cd_enable(pin_en[5]), .always_on_linear_ok(always_on_linear_ok),
    .serial_logic_supply_ok(serial_logic_supply_ok), .rail_good(rail_good),
    .rail_discharged(rail_discharged), .dac_slewing(dac_slewing),
    .undervolt_warn(cond[0]), .overtemp_warn(cond[1]), .undervolt_fault(cond[2]),
    .overtemp_fault(cond[3]), .rail_enable(rail_enable),
    .standby_select(standby_select), .second_target_voltage(second_target_voltage),
    .rails_ok_out_oe(rails_ok_out_oe));

  host_button_model u_host (.clk(clk), .resetn(resetn), .press_req(press_req),
    .ack_enable(ack_enable), .ack_delay(ack_delay), .wake_oe(wake_oe),
    .press_n(press_n), .host_power_ack(host_power_ack));

  always #50 clk = ~clk;

  function automatic logic [31:0] observe(input int s);
    case (s)
      0: return rd;
      1: return {31'h0, er};
      2: return {31'h0, wake_oe};
      3: return {31'h0, reset_out_n_oe};
      4: return {31'h0, interrupt_n_oe};
      5: return {31'h0, button_status_oe};
      6: return {31'h0, rails_ok_out_oe};
      7: return {25'h0, rail_enable};
      8: return {28'h0, second_target_voltage};
      default: return {26'h0, rd[5:0]};
    endcase
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check(input string nm, input int s, input logic [31:0] e);
    note_type t;
    t.name = nm;
    t.sel = s;
    t.exp = e;
    notes.push_back(t);
    ->result_ev;
  endtask

  task automatic at(input string nm, input int s, input logic [31:0] e, input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
    check(nm, s, e);
  endtask

  task automatic await(input string nm, input int s, input logic [31:0] e, input int n);
    repeat (n) begin
      @(negedge clk);
      if (observe(s) === e) break;
    end
    check(nm, s, e);
  endtask

  // oldest note against the output it names
  always @(result_ev) begin
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      n_compared++;
      if (observe(cur.sel) !== cur.exp) begin
        err_count++;
        $display("[FAIL] %s expected %h seen %h", cur.name, cur.exp, observe(cur.sel));
      end
    end
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {press_req, ack_enable, pin_en, cond, dac_slewing, standby_select} = '0;
    ack_delay = 8'h0a;
    always_on_linear_ok = 1'b1;
    serial_logic_supply_ok = 1'b1;
    rail_good = 7'h7f;
    rail_discharged = 7'h7f;
    err_count = 0;
    n_compared = 0;
    void'($urandom(94836));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    at("wake_oe", 2, 1, 1);
    check("rails_ok_out_oe", 6, 1);
    check("reset_out_n_oe", 3, 0);
    @(posedge clk);
    always_on_linear_ok <= 1'b0;
    await("reset_out_n_oe", 3, 1, 4);
    @(posedge clk);
    always_on_linear_ok <= 1'b1;
    await("reset_out_n_oe", 3, 0, 4);
    // short press: mirrored after debounce, no wake
    @(posedge clk);
    press_req <= 1'b1;
    at("button_status_oe", 5, 0, DEB - 2);
    await("button_status_oe", 5, 1, 6);
    @(posedge clk);
    press_req <= 1'b0;
    at("button_status_oe", 5, 1, DEB - 3);
    await("button_status_oe", 5, 0, 8);
    check("wake_oe", 2, 1);
    // long press, host acknowledges, then drops
    @(posedge clk);
    ack_enable <= 1'b1;
    press_req <= 1'b1;
    await("wake_oe", 2, 0, WAKE + 4);
    @(posedge clk);
    press_req <= 1'b0;
    at("wake_oe", 2, 0, ACKT + 10);
    @(posedge clk);
    ack_enable <= 1'b0;
    await("wake_oe", 2, 1, 4);
    // long press, host silent
    repeat (WOFF + 5) @(posedge clk);
    press_req <= 1'b1;
    await("wake_oe", 2, 0, WAKE + 4);
    @(posedge clk);
    press_req <= 1'b0;
    at("wake_oe", 2, 0, ACKT - 15);
    await("wake_oe", 2, 1, 25);
    repeat (WOFF + 5) @(posedge clk);
    // rail enables, power-good
    pin_en <= 6'h3f;
    at("rail_enable", 7, 0, 1990);
    await("rail_enable", 7, 32'h7f, 20);
    await("rails_ok_out_oe", 6, 0, 4);
    @(posedge clk);
    rail_good <= 7'h7b;
    await("rails_ok_out_oe", 6, 1, 4);
    @(posedge clk);
    rail_good <= 7'h7f;
    dac_slewing <= 1'b1;
    at("rails_ok_out_oe", 6, 1, 3);
    apb(1'b1, pmic_pins_pkg::CTRL_OFFSET, 32'h0000_0600);
    await("rails_ok_out_oe", 6, 0, 4);
    await("rail_enable", 7, 32'h3f, 2010);
    @(posedge clk);
    dac_slewing <= 1'b0;
    pin_en <= 6'h00;
    rail_discharged <= 7'h7e;
    await("rail_enable", 7, 0, 2010);
    await("rails_ok_out_oe", 6, 1, 4);
    @(posedge clk);
    pin_en <= 6'h01;
    at("rail_enable", 7, 0, 2010);
    @(posedge clk);
    rail_discharged <= 7'h7f;
    await("rail_enable", 7, 1, 2010);
    // hard reset by a 200-cycle hold
    @(posedge clk);
    ack_enable <= 1'b1;
    press_req <= 1'b1;
    await("reset_out_n_oe", 3, 1, HARD + 5);
    @(posedge clk);
    press_req <= 1'b0;
    await("wake_oe", 2, 1, 4);
    await("rail_enable", 7, 0, 4);
    at("reset_out_n_oe", 3, 1, HOLD - 15);
    check("rail_enable", 7, 0);
    await("reset_out_n_oe", 3, 0, 25);
    // latched causes and clearing
    apb(1'b0, pmic_pins_pkg::STATUS_OFFSET, 32'h0);
    check("cause", 9, 32'h21);
    apb(1'b1, pmic_pins_pkg::CLEAR_OFFSET, $urandom);
    await("interrupt_n_oe", 4, 0, 4);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      cond[i] <= 1'b1;
      @(posedge clk);
      cond[i] <= 1'b0;
      await("interrupt_n_oe", 4, 1, 4);
      at("interrupt_n_oe", 4, 1, 6);
      apb(1'b0, pmic_pins_pkg::STATUS_OFFSET, 32'h0);
      check("cause", 9, 32'h1 << (i + 1));
      apb(1'b1, pmic_pins_pkg::CLEAR_OFFSET, $urandom);
      await("interrupt_n_oe", 4, 0, 4);
    end
    @(posedge clk);
    cond[1] <= 1'b1;
    apb(1'b1, pmic_pins_pkg::CLEAR_OFFSET, 32'h0);
    at("interrupt_n_oe", 4, 1, 3);
    @(posedge clk);
    cond[1] <= 1'b0;
    apb(1'b1, pmic_pins_pkg::CLEAR_OFFSET, 32'h0);
    await("interrupt_n_oe", 4, 0, 4);
    // dac target select and serial supply loss
    repeat (3) begin
      v = 4'($urandom);
      apb(1'b1, pmic_pins_pkg::VSEL_OFFSET, {28'h0, v});
      await("second_target_voltage", 8, {28'h0, v}, 3);
      apb(1'b0, pmic_pins_pkg::VSEL_OFFSET, 32'h0);
      check("vsel", 0, {28'h0, v});
    end
    // standby forces every dac onto its second target
    @(posedge clk);
    standby_select <= 1'b1;
    await("second_target_voltage", 8, 32'hf, 3);
    @(posedge clk);
    standby_select <= 1'b0;
    await("second_target_voltage", 8, {28'h0, v}, 3);
    @(posedge clk);
    serial_logic_supply_ok <= 1'b0;
    @(posedge clk);
    serial_logic_supply_ok <= 1'b1;
    apb(1'b0, pmic_pins_pkg::VSEL_OFFSET, 32'h0);
    check("vsel", 0, 32'h0);
    await("second_target_voltage", 8, 32'h0, 3);
    apb(1'b0, pmic_pins_pkg::CTRL_OFFSET, 32'h0);
    check("ctrl", 0, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check("pslverr", 1, 32'h1);
    check("unmapped", 0, 32'h0);
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule
